// ===== design/trm_pkg.sv
package trm_pkg;

	// Time base: a 1 ms tick is derived from the 50 ns bus clock.
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned MS_NS         = 1_000_000;
	localparam int unsigned TICK_DEF      = MS_NS / CLK_PERIOD_NS;
	localparam logic [15:0] REQ_STEP_MS   = 16'h0004;
	localparam logic [15:0] JDET_DEF_MS   = 16'h0064;

	// Value ranges of the management tables.
	localparam int          NODE_CNT    = 255;
	localparam logic [7:0]  NODE_MIN    = 8'h01;
	localparam logic [7:0]  NODE_MAX    = 8'hFE;
	localparam logic [7:0]  TWD_MIN     = 8'h01;
	localparam logic [7:0]  MFI_MAX     = 8'h32;
	localparam logic [15:0] AREA1_MAX   = 16'h01FF;
	localparam logic [15:0] AREA2_MAX   = 16'h1FFF;
	localparam logic [1:0]  MISS_LAST   = 2'h2;
	localparam logic [1:0]  HALF_CIRCS  = 2'h3;
	localparam logic [31:0] SEQ_FIRST   = 32'h00000001;
	localparam logic [31:0] P2P_MAX     = 32'h0FFFFFFF;
	localparam logic [31:0] BC_MAX      = 32'hFFFFFFFF;
	// Protocol version code; the value is arbitrary.
	localparam logic [7:0]  PROTO_VER   = 8'h5A;

	// Reset values.
	localparam logic [7:0]  NODE_RST    = 8'h01;
	localparam logic [7:0]  TWD_RST     = 8'h01;

	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_JDET   = 8'h04;
	localparam logic [7:0] OFS_STAT   = 8'h08;
	localparam logic [7:0] OFS_NODE   = 8'h0C;
	localparam logic [7:0] OFS_A1TOP  = 8'h10;
	localparam logic [7:0] OFS_A1SIZE = 8'h14;
	localparam logic [7:0] OFS_A2TOP  = 8'h18;
	localparam logic [7:0] OFS_A2SIZE = 8'h1C;
	localparam logic [7:0] OFS_USTAT  = 8'h20;
	localparam logic [7:0] OFS_TWD    = 8'h24;
	localparam logic [7:0] OFS_MFI    = 8'h28;
	localparam logic [7:0] OFS_LINK   = 8'h2C;
	localparam logic [7:0] OFS_OSTAT  = 8'h30;
	localparam logic [7:0] OFS_PVER   = 8'h34;
	localparam logic [7:0] OFS_HOLD   = 8'h38;
	localparam logic [7:0] OFS_NMFI   = 8'h3C;
	localparam logic [7:0] OFS_RCT    = 8'h40;
	localparam logic [7:0] OFS_RCCUR  = 8'h44;
	localparam logic [7:0] OFS_RCMAX  = 8'h48;
	localparam logic [7:0] OFS_RCMIN  = 8'h4C;
	localparam logic [7:0] OFS_SEL    = 8'h50;
	localparam logic [7:0] OFS_ENT0   = 8'h54;
	localparam logic [7:0] OFS_ENT1   = 8'h58;
	localparam logic [7:0] OFS_ENT2   = 8'h5C;
	localparam logic [7:0] OFS_ENT3   = 8'h60;
	localparam logic [7:0] OFS_TXVER  = 8'h64;
	localparam logic [7:0] OFS_TXP2P  = 8'h68;
	localparam logic [7:0] OFS_TXBC   = 8'h6C;
	localparam logic [7:0] OFS_RXVER  = 8'h70;
	localparam logic [7:0] OFS_RXP2P  = 8'h74;
	localparam logic [7:0] OFS_RXBC   = 8'h78;
	localparam logic [2:0] ID_REGION  = 3'h4;

	// Membership phases.
	typedef enum logic [5:0] {
		M_IDLE   = 6'h01,
		M_LISTEN = 6'h02,
		M_TRIG   = 6'h04,
		M_HALF   = 6'h08,
		M_WAIT   = 6'h10,
		M_JOINED = 6'h20
	} trm_mode_t;

	// Per-node parameters carried by token and participation frames.
	typedef struct packed {
		logic [15:0] ustat;
		logic [15:0] a1top;
		logic [15:0] a1size;
		logic [15:0] a2top;
		logic [15:0] a2size;
		logic [15:0] rct;
		logic [7:0]  twd;
		logic [7:0]  mfi;
		logic [7:0]  link;
	} trm_info_t;

	// One participating node table entry.
	typedef struct packed {
		logic       present;
		logic [1:0] miss;
		trm_info_t  info;
	} trm_entry_t;

	// One received frame event, a pulse of one cycle.
	typedef struct packed {
		logic      tok;
		logic      trig;
		logic      req;
		logic [7:0] src;
		logic [7:0] dst;
		trm_info_t info;
	} trm_frame_t;

	// Own-node settings written from the network.
	typedef struct packed {
		logic        valid;
		logic [7:0]  node;
		logic [15:0] a1top;
		logic [15:0] a1size;
		logic [15:0] a2top;
		logic [15:0] a2size;
	} trm_netset_t;

	// Message sequence data.
	typedef struct packed {
		logic [31:0] ver;
		logic [31:0] p2p;
		logic [31:0] bc;
	} trm_seq_t;

	// Sequence events from the message layer.
	typedef struct packed {
		logic     tx_p2p;
		logic     tx_bc;
		logic     rx_valid;
		trm_seq_t rx;
	} trm_seqin_t;

	// Own node table as offered to the frame builder.
	typedef struct packed {
		logic [7:0] node;
		trm_info_t  info;
		logic [7:0] ostat;
		logic [7:0] pver;
	} trm_own_t;

endpackage : trm_pkg

// ===== design/trm_node.sv
// How it works
// - Token during detection time means network running.
// - Token to lowest node starts a circulation.
// - Participation request after node times 4 ms.
// - Every token frame marks its sender present.
// - Three missed circulations remove a node.
// - First token updates node and network tables.
// - Each token frame refreshes the sender entry.
// - Participation request adds or refreshes entry.
// - Token holder number is one byte, 1-254.
// - Token watchdog is one byte, 1-255 ms.
// - Frame interval is one byte, 0-50.
// - Refresh times are two bytes in ms.
// - Area 1 address and size up to 0x1FF.
// - Area 2 size up to 0x1FFF, own top 0x1FF.
// - Two-byte upper-layer status per node.
// - Own settings from software and from network.
// - Own table offered for request and reads.
// - Identity strings, link and own status held.
// - Sequence counters wrap back to one.
// - Sequence version numbers kept both ways.
// - Token passes to next higher node, wraps.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps

module trm_node #(
	parameter int unsigned TICK_CYCLES = trm_pkg::TICK_DEF
) (
	// Clock and reset.
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB register slave.
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Events from the frame and message layers.
	input  trm_pkg::trm_frame_t     rx_frame,
	input  trm_pkg::trm_netset_t    net_set,
	input  trm_pkg::trm_seqin_t     seq_in,
	// Membership results.
	output logic                    join_req,
	output logic                    circ_start,
	output logic                    node_removed,
	output logic      [7:0]         removed_node,
	output logic      [7:0]         tok_next,
	output logic                    net_running,
	output trm_pkg::trm_own_t       own_tbl,
	output trm_pkg::trm_seq_t       seq_tx
);
	import trm_pkg::*;

	// Whole state of the block in one record.
	typedef struct packed {
		trm_mode_t               mode;
		logic [15:0]             tick_cnt;
		logic                    ms_tick;
		logic [15:0]             ms_cnt;
		logic [1:0]              circ_cnt;
		logic                    first_tok;
		logic                    running;
		logic [15:0]             rc_cnt;
		logic                    rc_seen;
		logic [7:0]              wd_cnt;
		logic [15:0]             jdet;
		trm_own_t                own;
		logic [7:0]              hold;
		logic [7:0]              net_mfi;
		logic [15:0]             net_rct;
		logic [15:0]             rc_cur;
		logic [15:0]             rc_max;
		logic [15:0]             rc_min;
		logic [7:0]              sel;
		trm_seq_t                tx;
		trm_seq_t                rx;
		logic [7:0][31:0]        ids;
		trm_entry_t [NODE_CNT-1:0] tbl;
		logic                    join_req;
		logic                    circ_start;
		logic                    removed;
		logic [7:0]              removed_node;
		logic [7:0]              tok_next;
		logic                    pready;
		logic                    pslverr;
		logic [31:0]             prdata;
	} trm_state_t;

	trm_state_t s;       // Registered state.
	trm_state_t next_s;  // Next state.

	// Next-state logic: time base, membership phases, tables and the APB slave.
	always_comb begin
		logic [7:0]  lo;
		logic [7:0]  nxt;
		logic [7:0]  mfi_max;
		logic [31:0] rd;
		logic        hit;
		logic [7:0]  a;
		lo = 8'h00;
		nxt = 8'h00;
		mfi_max = 8'h00;
		rd = 32'h00000000;
		hit = 1'b1;
		a = paddr;
		next_s = s;
		next_s.join_req = 1'b0;
		next_s.circ_start = 1'b0;
		next_s.removed = 1'b0;

		// Free-running millisecond tick; phases that need exact delays restart it.
		next_s.ms_tick = 1'b0;
		if (s.tick_cnt == 16'(TICK_CYCLES - 1)) begin
			next_s.tick_cnt = 16'h0000;
			next_s.ms_tick = 1'b1;
		end else begin
			next_s.tick_cnt = s.tick_cnt + 16'h0001;
		end

		// Scan the table for the lowest node, our successor and the widest interval.
		if (s.mode == M_JOINED) begin
			mfi_max = s.own.info.mfi;
		end
		for (int i = 1; i < NODE_CNT; i++) begin
			if (s.tbl[i].present) begin
				if (lo == 8'h00) begin
					lo = 8'(i);
				end
				if (nxt == 8'h00 && 8'(i) > s.own.node) begin
					nxt = 8'(i);
				end
				if (s.tbl[i].info.mfi > mfi_max) begin
					mfi_max = s.tbl[i].info.mfi;
				end
			end
		end
		// The highest node hands back to the lowest one.
		if (nxt == 8'h00) begin
			nxt = lo;
		end
		next_s.tok_next = nxt;
		next_s.net_mfi = mfi_max;

		// Refresh cycle time runs in ms between two circulation starts.
		if (s.ms_tick && s.rc_cnt != 16'hFFFF) begin
			next_s.rc_cnt = s.rc_cnt + 16'h0001;
		end

		// Phase timers count down on the ms tick.
		if ((s.mode == M_LISTEN || s.mode == M_WAIT) && s.ms_tick && s.ms_cnt != 16'h0000) begin
			next_s.ms_cnt = s.ms_cnt - 16'h0001;
		end
		unique case (s.mode)
			M_IDLE, M_TRIG, M_HALF, M_JOINED: begin
			end
			M_LISTEN: begin
				// Silence for the whole detection time means a new network.
				if (s.ms_cnt == 16'h0000) begin
					next_s.mode = M_TRIG;
				end
			end
			M_WAIT: begin
				if (s.ms_cnt == 16'h0000) begin
					next_s.join_req = 1'b1;
					next_s.mode = M_JOINED;
				end
			end
		endcase

		// Token watchdog: a silent holder is counted as having missed a round.
		if (s.first_tok && s.ms_tick) begin
			if (s.wd_cnt + 8'h01 >= s.own.info.twd) begin
				next_s.wd_cnt = 8'h00;
				// A token from the holder in this very cycle outranks the timeout.
				if (s.hold >= NODE_MIN && s.hold <= NODE_MAX && s.tbl[s.hold].present
				    && !(rx_frame.tok && rx_frame.src == s.hold)) begin
					if (s.tbl[s.hold].miss == MISS_LAST) begin
						next_s.tbl[s.hold].present = 1'b0;
						next_s.removed = 1'b1;
						next_s.removed_node = s.hold;
					end else begin
						next_s.tbl[s.hold].miss = s.tbl[s.hold].miss + 2'h1;
					end
				end
			end else begin
				next_s.wd_cnt = s.wd_cnt + 8'h01;
			end
		end

		// Token frame handling.
		if (rx_frame.tok) begin
			next_s.wd_cnt = 8'h00;
			if (s.mode == M_LISTEN) begin
				next_s.mode = M_HALF;
				next_s.running = 1'b1;
				next_s.circ_cnt = 2'h0;
			end
			if (rx_frame.dst >= NODE_MIN && rx_frame.dst <= NODE_MAX) begin
				next_s.hold = rx_frame.dst;
			end
			if (!s.first_tok) begin
				next_s.first_tok = 1'b1;
				next_s.net_rct = rx_frame.info.rct;
			end
			if (lo != 8'h00 && rx_frame.dst == lo) begin
				next_s.circ_start = 1'b1;
				next_s.rc_cnt = 16'h0000;
				next_s.rc_seen = 1'b1;
				// The first start only opens the measurement window.
				if (s.rc_seen) begin
					next_s.rc_cur = s.rc_cnt;
					if (s.rc_cnt > s.rc_max) begin
						next_s.rc_max = s.rc_cnt;
					end
					if (s.rc_cnt < s.rc_min) begin
						next_s.rc_min = s.rc_cnt;
					end
				end
				if (s.mode == M_HALF) begin
					next_s.circ_cnt = s.circ_cnt + 2'h1;
					if (s.circ_cnt + 2'h1 == HALF_CIRCS) begin
						next_s.mode = M_WAIT;
						next_s.ms_cnt = 16'(s.own.node) * REQ_STEP_MS;
						next_s.tick_cnt = 16'h0000;
					end
				end
				// Every present node ages by one round; the sender of this token is spared,
				// so a node is never reported removed in the cycle its token is heard.
				for (int i = 1; i < NODE_CNT; i++) begin
					if (s.tbl[i].present && 8'(i) != rx_frame.src) begin
						if (s.tbl[i].miss == MISS_LAST) begin
							next_s.tbl[i].present = 1'b0;
							next_s.removed = 1'b1;
							next_s.removed_node = 8'(i);
						end else begin
							next_s.tbl[i].miss = s.tbl[i].miss + 2'h1;
						end
					end
				end
			end
			if (rx_frame.src >= NODE_MIN && rx_frame.src <= NODE_MAX) begin
				next_s.tbl[rx_frame.src].present = 1'b1;
				next_s.tbl[rx_frame.src].miss = 2'h0;
				next_s.tbl[rx_frame.src].info = rx_frame.info;
			end
		end

		// The first trigger frame starts the request wait; later ones are ignored.
		if (rx_frame.trig && s.mode == M_TRIG) begin
			next_s.mode = M_WAIT;
			next_s.running = 1'b1;
			next_s.ms_cnt = 16'(s.own.node) * REQ_STEP_MS;
			next_s.tick_cnt = 16'h0000;
		end

		// A participation request adds or refreshes its sender.
		if (rx_frame.req && rx_frame.src >= NODE_MIN && rx_frame.src <= NODE_MAX) begin
			next_s.tbl[rx_frame.src].present = 1'b1;
			next_s.tbl[rx_frame.src].miss = 2'h0;
			next_s.tbl[rx_frame.src].info = rx_frame.info;
		end

		// Network writes to the own-node settings; out-of-range fields are ignored.
		if (net_set.valid) begin
			if (net_set.node >= NODE_MIN && net_set.node <= NODE_MAX) begin
				next_s.own.node = net_set.node;
			end
			if (net_set.a1top <= AREA1_MAX) begin
				next_s.own.info.a1top = net_set.a1top;
			end
			if (net_set.a1size <= AREA1_MAX) begin
				next_s.own.info.a1size = net_set.a1size;
			end
			if (net_set.a2top <= AREA1_MAX) begin
				next_s.own.info.a2top = net_set.a2top;
			end
			if (net_set.a2size <= AREA2_MAX) begin
				next_s.own.info.a2size = net_set.a2size;
			end
		end

		// Sequence counters skip zero when they wrap.
		if (seq_in.tx_p2p) begin
			next_s.tx.p2p = (s.tx.p2p >= P2P_MAX) ? SEQ_FIRST : s.tx.p2p + SEQ_FIRST;
		end
		if (seq_in.tx_bc) begin
			next_s.tx.bc = (s.tx.bc == BC_MAX) ? SEQ_FIRST : s.tx.bc + SEQ_FIRST;
		end
		if (seq_in.rx_valid) begin
			next_s.rx = seq_in.rx;
		end

		// Register read multiplexer.
		if (a[7:5] == ID_REGION) begin
			rd = s.ids[a[4:2]];
		end else begin
			unique case (a)
				OFS_CTRL:   rd = 32'h00000000;
				OFS_JDET:   rd = 32'(s.jdet);
				OFS_STAT:   rd = {8'h00, s.hold, 6'h00, s.running, s.first_tok, 2'h0, s.mode};
				OFS_NODE:   rd = 32'(s.own.node);
				OFS_A1TOP:  rd = 32'(s.own.info.a1top);
				OFS_A1SIZE: rd = 32'(s.own.info.a1size);
				OFS_A2TOP:  rd = 32'(s.own.info.a2top);
				OFS_A2SIZE: rd = 32'(s.own.info.a2size);
				OFS_USTAT:  rd = 32'(s.own.info.ustat);
				OFS_TWD:    rd = 32'(s.own.info.twd);
				OFS_MFI:    rd = 32'(s.own.info.mfi);
				OFS_LINK:   rd = 32'(s.own.info.link);
				OFS_OSTAT:  rd = 32'(s.own.ostat);
				OFS_PVER:   rd = 32'(s.own.pver);
				OFS_HOLD:   rd = 32'(s.hold);
				OFS_NMFI:   rd = 32'(s.net_mfi);
				OFS_RCT:    rd = 32'(s.net_rct);
				OFS_RCCUR:  rd = 32'(s.rc_cur);
				OFS_RCMAX:  rd = 32'(s.rc_max);
				OFS_RCMIN:  rd = 32'(s.rc_min);
				OFS_SEL:    rd = 32'(s.sel);
				OFS_ENT0:   rd = {s.tbl[s.sel].info.link, s.tbl[s.sel].info.twd,
				                  s.tbl[s.sel].info.mfi, 5'h00, s.tbl[s.sel].miss,
				                  s.tbl[s.sel].present};
				OFS_ENT1:   rd = {s.tbl[s.sel].info.ustat, s.tbl[s.sel].info.rct};
				OFS_ENT2:   rd = {s.tbl[s.sel].info.a1top, s.tbl[s.sel].info.a1size};
				OFS_ENT3:   rd = {s.tbl[s.sel].info.a2top, s.tbl[s.sel].info.a2size};
				OFS_TXVER:  rd = s.tx.ver;
				OFS_TXP2P:  rd = s.tx.p2p;
				OFS_TXBC:   rd = s.tx.bc;
				OFS_RXVER:  rd = s.rx.ver;
				OFS_RXP2P:  rd = s.rx.p2p;
				OFS_RXBC:   rd = s.rx.bc;
				default: begin
					hit = 1'b0;
				end
			endcase
		end

		// APB: one wait state; data and error are registered on the same edge on which pready rises.
		if (psel && penable && !s.pready) begin
			next_s.pready = 1'b1;
			next_s.prdata = rd;
			next_s.pslverr = !hit;
		end else begin
			next_s.pready = 1'b0;
			next_s.pslverr = 1'b0;
		end
		// Writes land only on the edge where the master sees pready high.
		if (psel && penable && s.pready && pwrite && hit) begin
			if (a[7:5] == ID_REGION) begin
				next_s.ids[a[4:2]] = pwdata;
			end else begin
				unique case (a)
					OFS_CTRL: begin
						// Any write with bit 0 set (re)starts joining; tables are kept.
						if (pwdata[0]) begin
							next_s.mode = M_LISTEN;
							next_s.ms_cnt = s.jdet;
							next_s.tick_cnt = 16'h0000;
							next_s.first_tok = 1'b0;
							next_s.running = 1'b0;
							next_s.rc_seen = 1'b0;
						end
					end
					OFS_JDET: next_s.jdet = pwdata[15:0];
					OFS_NODE: begin
						if (pwdata[7:0] >= NODE_MIN && pwdata[7:0] <= NODE_MAX) begin
							next_s.own.node = pwdata[7:0];
						end
					end
					OFS_A1TOP: begin
						if (pwdata[15:0] <= AREA1_MAX) next_s.own.info.a1top = pwdata[15:0];
					end
					OFS_A1SIZE: begin
						if (pwdata[15:0] <= AREA1_MAX) next_s.own.info.a1size = pwdata[15:0];
					end
					OFS_A2TOP: begin
						if (pwdata[15:0] <= AREA1_MAX) next_s.own.info.a2top = pwdata[15:0];
					end
					OFS_A2SIZE: begin
						if (pwdata[15:0] <= AREA2_MAX) next_s.own.info.a2size = pwdata[15:0];
					end
					OFS_USTAT: next_s.own.info.ustat = pwdata[15:0];
					OFS_TWD: begin
						if (pwdata[7:0] >= TWD_MIN) next_s.own.info.twd = pwdata[7:0];
					end
					OFS_MFI: begin
						if (pwdata[7:0] <= MFI_MAX) next_s.own.info.mfi = pwdata[7:0];
					end
					OFS_LINK:  next_s.own.info.link = pwdata[7:0];
					OFS_OSTAT: next_s.own.ostat = pwdata[7:0];
					OFS_RCT:   next_s.net_rct = pwdata[15:0];
					OFS_SEL:   next_s.sel = (pwdata[7:0] > NODE_MAX) ? NODE_MAX : pwdata[7:0];
					OFS_TXVER: next_s.tx.ver = pwdata;
					OFS_TXP2P: begin
						if (pwdata >= SEQ_FIRST && pwdata <= P2P_MAX) next_s.tx.p2p = pwdata;
					end
					OFS_TXBC: begin
						// Zero is never a valid sequence number.
						if (pwdata >= SEQ_FIRST) next_s.tx.bc = pwdata;
					end
					default: begin
					end
				endcase
			end
		end
		// The request frame always carries the current refresh time.
		next_s.own.info.rct = next_s.net_rct;
	end

	// State register; all fields take constants on reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.mode <= M_IDLE;
			s.jdet <= JDET_DEF_MS;
			s.own.node <= NODE_RST;
			s.own.info.twd <= TWD_RST;
			s.own.pver <= PROTO_VER;
			s.rc_min <= 16'hFFFF;
			s.tx.p2p <= SEQ_FIRST;
			s.tx.bc <= SEQ_FIRST;
		end else begin
			s <= next_s;
		end
	end

	// Outputs come straight from the state register.
	assign prdata       = s.prdata;
	assign pready       = s.pready;
	assign pslverr      = s.pslverr;
	assign join_req     = s.join_req;
	assign circ_start   = s.circ_start;
	assign node_removed = s.removed;
	assign removed_node = s.removed_node;
	assign tok_next     = s.tok_next;
	assign net_running  = s.running;
	assign own_tbl      = s.own;
	assign seq_tx       = s.tx;

endmodule : trm_node

// ===== bench/trm_peer.sv
`timescale 1ns/1ps
// Stands in for the other nodes of the ring: it emits token, trigger and request events.
module trm_peer import trm_pkg::*; (
	// Clock.
	input  wire logic pclk,
	// Frame events into the node.
	output trm_frame_t rx_frame
);
	initial rx_frame = '0;

	// One event pulse; afterwards the addresses turn to garbage so no stale value passes.
	task automatic send(input logic t, g, r, input logic [7:0] s, d);
		@(posedge pclk);
		rx_frame <= '{tok: t, trig: g, req: r, src: s, dst: d,
			info: '{ustat: {8'hA0, s}, rct: {8'h00, s}, twd: 8'h01, default: '0}};
		@(posedge pclk);
		rx_frame.tok  <= 1'b0;
		rx_frame.trig <= 1'b0;
		rx_frame.req  <= 1'b0;
		rx_frame.src  <= ~s;
		rx_frame.dst  <= ~d;
	endtask : send
endmodule : trm_peer

// ===== bench/trm_node_checker.sv
`timescale 1ns/1ps
// Watches the node's ports for bus timing, event causes and table limits.
module trm_node_checker import trm_pkg::*; (
	// Clock, reset and bus.
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input logic                   pready,
	input logic                   pslverr,
	// Events and results.
	input trm_pkg::trm_frame_t    rx_frame,
	input logic                   join_req,
	input logic                   circ_start,
	input logic                   node_removed,
	input logic [7:0]             removed_node,
	input logic                   net_running,
	input trm_pkg::trm_own_t      own_tbl,
	input trm_pkg::trm_seq_t      seq_tx
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	ready_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready too long");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	circ_cause_a: assert property (circ_start |-> $past(rx_frame.tok) || $past(rx_frame.tok, 2))
		else $error("circ_start without token");
	run_cause_a: assert property ($rose(net_running) |-> $past(rx_frame.tok)
		|| $past(rx_frame.trig) || $past(rx_frame.tok, 2) || $past(rx_frame.trig, 2))
		else $error("running without cause");
	join_run_a: assert property (join_req |-> net_running ##1 !join_req)
		else $error("bad join_req");
	rem_range_a: assert property (node_removed |-> removed_node inside {[NODE_MIN:NODE_MAX]})
		else $error("bad removed node");
	node_range_a: assert property (own_tbl.node inside {[NODE_MIN:NODE_MAX]})
		else $error("own node out of range");
	twd_mfi_a: assert property (own_tbl.info.twd >= TWD_MIN && own_tbl.info.mfi <= MFI_MAX)
		else $error("twd or mfi out of range");
	area_lim_a: assert property (own_tbl.info.a1top <= AREA1_MAX
		&& own_tbl.info.a1size <= AREA1_MAX && own_tbl.info.a2size <= AREA2_MAX)
		else $error("area out of range");
	seq_range_a: assert property (seq_tx.p2p inside {[SEQ_FIRST:P2P_MAX]} && seq_tx.bc != '0)
		else $error("sequence out of range");

	c_circ: cover property (circ_start);
	c_join: cover property (join_req);
	c_rem: cover property (node_removed);
	c_err: cover property (pslverr);
endmodule : trm_node_checker

bind trm_node trm_node_checker u_trm_node_checker (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .rx_frame, .join_req, .circ_start, .node_removed, .removed_node, .net_running,
	.own_tbl, .seq_tx);

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import trm_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, join_req, circ_start, node_removed, net_running, e;
	logic [7:0]  removed_node, tok_next, last_rem = 8'h00;
	trm_frame_t  rx_frame;
	trm_netset_t net_set = '0;
	trm_seqin_t  seq_in = '0;
	trm_own_t    own_tbl;
	trm_seq_t    seq_tx;
	int fail_count = 0, checks = 0, cyc = 0, n_circ = 0, n_rem = 0, n_join = 0, t_jreq = 0;

	// A short tick keeps the millisecond waits cheap: 1 ms is 10 cycles here.
	trm_node #(.TICK_CYCLES(10)) u_trm_node (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rx_frame, .net_set, .seq_in, .join_req, .circ_start,
		.node_removed, .removed_node, .tok_next, .net_running, .own_tbl, .seq_tx);
	trm_peer u_trm_peer (.pclk, .rx_frame);

	always #25 pclk = ~pclk;

	// Event pulses are counted here so scenarios can judge them afterwards.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		n_circ <= n_circ + (circ_start === 1'b1);
		n_rem <= n_rem + (node_removed === 1'b1);
		if (join_req === 1'b1) begin
			n_join <= n_join + 1;
			t_jreq <= cyc;
		end
		if (node_removed === 1'b1) begin
			last_rem <= removed_node;
		end
	end

	task automatic final_report();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	task automatic cmp(input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	// One APB transfer; the request holds until pready is seen at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		cmp(n < 50, 32'h1);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		cmp(q, x);
	endtask : rd

	task automatic wchk(input logic [7:0] a, input logic [31:0] w, x);
		apb(1'b1, a, w);
		rd(a, x);
	endtask : wchk

	task automatic rst();
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
	endtask : rst

	// Reset values, an unmapped word, and refused out-of-range writes.
	task automatic t_regs();
		rd(OFS_STAT, 32'h1);
		rd(OFS_JDET, 32'h64);
		rd(OFS_PVER, {24'h0, PROTO_VER});
		rd(OFS_RCMIN, 32'hFFFF);
		apb(1'b0, 8'hFC, 32'h0);
		cmp({q, e}, 33'h1);
		wchk(OFS_NODE, 32'h0, 32'h1);
		wchk(OFS_NODE, 32'hFF, 32'h1);
		wchk(OFS_NODE, 32'h3, 32'h3);
		wchk(OFS_TWD, 32'h0, 32'h1);
		wchk(OFS_TWD, 32'hFF, 32'hFF);
		wchk(OFS_MFI, 32'h33, 32'h0);
		wchk(OFS_MFI, 32'h32, 32'h32);
		wchk(OFS_A1TOP, 32'h200, 32'h0);
		wchk(OFS_A1SIZE, 32'h1FF, 32'h1FF);
		wchk(OFS_A2SIZE, 32'h2000, 32'h0);
		wchk(OFS_A2SIZE, 32'h1FFF, 32'h1FFF);
		wchk(OFS_RCT, 32'hFFFF, 32'hFFFF);
		wchk(OFS_USTAT, 32'h1234, 32'h1234);
		cmp(own_tbl.node, 32'h3);
	endtask : t_regs

	// The point-to-point counter wraps to one, the broadcast counter steps to two, and the received version is stored.
	task automatic t_seq();
		wchk(OFS_TXP2P, P2P_MAX, P2P_MAX);
		@(posedge pclk);
		seq_in <= '{tx_p2p: 1'b1, tx_bc: 1'b1, rx_valid: 1'b1, rx: {32'h7, 32'h8, 32'h9}};
		@(posedge pclk);
		seq_in <= '0;
		repeat (3) @(posedge pclk);
		cmp(seq_tx.p2p, SEQ_FIRST);
		cmp(seq_tx.bc, 32'h2);
		rd(OFS_RXVER, 32'h7);
	endtask : t_seq

	// Silent line, then a trigger: request after node 3 times 4 ms.
	task automatic t_join();
		int t0, j0;
		wchk(OFS_JDET, 32'h2, 32'h2);
		apb(1'b1, OFS_CTRL, 32'h1);
		repeat (40) @(posedge pclk);
		rd(OFS_STAT, 32'h4);
		cmp(net_running, 32'h0);
		j0 = n_join;
		u_trm_peer.send(1'b0, 1'b1, 1'b0, 8'h0, 8'h0);
		t0 = cyc;
		for (int i = 0; i < 300 && n_join == j0; i++) @(posedge pclk);
		cmp(t_jreq - t0 inside {[118:126]}, 32'h1);
		rd(OFS_STAT, 32'h220);
	endtask : t_join

	// Ascending ring of 2, 5 and optionally 7, closing back at node 2.
	task automatic round(input logic w7);
		u_trm_peer.send(1'b1, 1'b0, 1'b0, 8'h2, 8'h5);
		if (w7) begin
			u_trm_peer.send(1'b1, 1'b0, 1'b0, 8'h5, 8'h7);
			u_trm_peer.send(1'b1, 1'b0, 1'b0, 8'h7, 8'h2);
		end else begin
			u_trm_peer.send(1'b1, 1'b0, 1'b0, 8'h5, 8'h2);
		end
		repeat (4) @(posedge pclk);
	endtask : round

	// Joining a running ring, counting circulations, then losing node 7.
	task automatic t_half();
		int c0, j0, r0;
		rst();
		wchk(OFS_TWD, 32'hFF, 32'hFF);
		apb(1'b1, OFS_CTRL, 32'h1);
		c0 = n_circ;
		j0 = n_join;
		u_trm_peer.send(1'b1, 1'b0, 1'b0, 8'h2, 8'h5);
		rd(OFS_STAT, 32'h00050308);
		cmp(net_running, 32'h1);
		u_trm_peer.send(1'b1, 1'b0, 1'b0, 8'h5, 8'h7);
		u_trm_peer.send(1'b1, 1'b0, 1'b0, 8'h7, 8'h2);
		round(1'b1);
		round(1'b1);
		cmp(n_circ - c0, 32'h3);
		repeat (60) @(posedge pclk);
		cmp(n_join - j0, 32'h1);
		cmp(tok_next, 32'h2);
		rd(OFS_HOLD, 32'h2);
		r0 = n_rem;
		round(1'b0);
		cmp(n_rem - r0, 32'h0);
		round(1'b0);
		round(1'b0);
		cmp(n_rem - r0, 32'h1);
		cmp(last_rem, 32'h7);
		apb(1'b1, OFS_SEL, 32'h7);
		apb(1'b0, OFS_ENT0, 32'h0);
		cmp(q[0], 32'h0);
		apb(1'b1, OFS_SEL, 32'h5);
		apb(1'b0, OFS_ENT0, 32'h0);
		cmp(q[0], 32'h1);
	endtask : t_half

	// A request enters its sender, the network sets own fields, a silent holder drops out.
	task automatic t_req();
		int r0;
		u_trm_peer.send(1'b0, 1'b0, 1'b1, 8'h9, 8'h0);
		apb(1'b1, OFS_SEL, 32'h9);
		rd(OFS_ENT1, 32'hA0090009);
		@(posedge pclk);
		net_set <= '{1'b1, 8'h4, 16'h200, 16'h10, 16'h0, 16'h1FFF};
		@(posedge pclk);
		net_set <= '0;
		@(posedge pclk);
		cmp(own_tbl.node, 32'h4);
		cmp(own_tbl.info.a1top, 32'h0);
		cmp(own_tbl.info.a2size, 32'h1FFF);
		r0 = n_rem;
		wchk(OFS_TWD, 32'h2, 32'h2);
		repeat (60) @(posedge pclk);
		cmp(n_rem - r0, 32'h1);
		cmp(last_rem, 32'h2);
	endtask : t_req

	initial begin
		rst();
		t_regs();
		t_seq();
		t_join();
		t_half();
		t_req();
		final_report();
	end

	// The whole run needs some 600 cycles; this cuts a hang short.
	initial begin
		#1_000_000;
		fail_count++;
		final_report();
	end
endmodule : tb_top
